// ==== common/scp_link_if.sv ====
// serial link between the host end and the device end
// the shared data wire idles high; a driving end wins over the pull-up
`timescale 1ns/1ps
interface scp_link_if;
  logic sclk;
  logic port_select_n;
  logic host_o;
  logic host_oe;
  logic dev_o;
  logic dev_oe;
  logic sdio;

  // resolved level of the shared data wire
  assign sdio = dev_oe ? dev_o : (host_oe ? host_o : 1'b1);

  modport host (output sclk, output port_select_n, output host_o, output host_oe, input sdio);
  modport dev  (input sclk, input port_select_n, output dev_o, output dev_oe, input sdio);
endinterface // scp_link_if

// ==== common/scp_pkg.sv ====
// constants shared by both ends of the serial configuration port
// assumes pclk at 25 MHz and a link clock made by the host end
package scp_pkg;
  // device register map
  localparam logic [7:0] ADDR_CFG    = 8'h00;
  localparam logic [7:0] ADDR_DIR_A  = 8'h02;
  localparam logic [7:0] ADDR_DIR_B  = 8'h04;
  localparam logic [7:0] ADDR_DIR_C  = 8'h05;
  localparam logic [7:0] ADDR_CLOCK  = 8'h09;
  localparam logic [7:0] ADDR_XFER   = 8'hff;
  localparam logic [7:0] CLOCK_RST   = 8'h01;
  localparam logic [7:0] XFER_CMD    = 8'h01;
  localparam int         BIT_DCS     = 0;
  localparam int         BIT_LSB     = 6;
  localparam int         BIT_XFER    = 0;
  // instruction word layout
  localparam int         INSTR_W     = 16;
  localparam int         BIT_RD      = 15;
  localparam int         BIT_LEN_HI  = 14;
  localparam int         BIT_LEN_LO  = 13;
  localparam logic [3:0] INSTR_LAST  = 4'hf;
  localparam logic [2:0] BYTE_LAST   = 3'h7;
  localparam logic [1:0] LEN_STREAM  = 2'h3;
  // host register map (byte addresses)
  localparam logic [7:0] H_CTRL      = 8'h00;
  localparam logic [7:0] H_TXDATA    = 8'h04;
  localparam logic [7:0] H_RXDATA    = 8'h08;
  localparam logic [7:0] H_STATUS    = 8'h0c;
  localparam logic [7:0] H_DIV       = 8'h10;
  localparam int         CTRL_RD     = 8;
  localparam int         CTRL_LSB    = 11;
  // link clock timing
  localparam int         PCLK_NS     = 40;
  localparam int         SCLK_NS     = 320;
  localparam logic [7:0] DIV_RST     = 8'((SCLK_NS + 2 * PCLK_NS - 1) / (2 * PCLK_NS));
  localparam logic [7:0] DIV_MIN     = 8'h04;

  // bit reversal for lsb-first data bytes
  function automatic logic [7:0] scp_rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction
endpackage

// ==== core/scp_dev.sv ====
// device end: serial slave and double-buffered byte register space
// assumes the link pins are asynchronous to pclk and sclk is no faster than pclk/8
// How it works
// - clock and select pins are inputs only
// - data pin input on writes, driven on reads
// - most registers buffered until transfer commanded
// - 0x01 at 0xff applies pending values
// - clock register resets 0x01, bit0 stabilizer
// - reset reloads defaults without serial access
// - master writes zero into reserved registers
// - master avoids writing undefined addresses
// - select low, 16-bit instruction, counted bytes
// - both length bits set means streaming
// - select high mid-byte resets serial machine
// - msb first after reset, config selectable
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module scp_dev
  import scp_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // serial link
  scp_link_if.dev         link,
  // user side view of the active registers
  input  wire logic [7:0] cfg_addr,
  output      logic [7:0] cfg_data,
  output      logic       dcs_enable,
  output      logic       lsb_first
);

  typedef enum logic [1:0] {ST_IDLE, ST_INSTR, ST_DATA, ST_DONE} scp_dev_state_t;

  logic [7:0]     shadow [256];
  logic [7:0]     active [256];
  logic [2:0]     sclk_s;
  logic [1:0]     cs_s;
  logic [1:0]     sd_s;
  logic           rise;
  logic           fall;
  logic           cs_n;
  logic           sd_in;

  scp_dev_state_t state;
  scp_dev_state_t next_state;
  logic [3:0]     bit_cnt;
  logic [3:0]     next_bit_cnt;
  logic [15:0]    instr_sr;
  logic [15:0]    next_instr_sr;
  logic [7:0]     rx_sr;
  logic [7:0]     next_rx_sr;
  logic [7:0]     tx_sr;
  logic [7:0]     next_tx_sr;
  logic [7:0]     addr;
  logic [7:0]     next_addr;
  logic [1:0]     left;
  logic [1:0]     next_left;
  logic           stream;
  logic           next_stream;
  logic           is_rd;
  logic           next_is_rd;
  logic           sd_o;
  logic           next_sd_o;
  logic           sd_oe;
  logic           next_sd_oe;

  logic           wr_en;
  logic [7:0]     wr_addr;
  logic [7:0]     wr_data;
  logic           xfer_en;

  // the link pins pass two flops; a third sclk flop gives the edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_s <= 3'h0;
      cs_s   <= 2'h3;
      sd_s   <= 2'h3;
    end else begin
      sclk_s <= {sclk_s[1:0], link.sclk};
      cs_s   <= {cs_s[0], link.port_select_n};
      sd_s   <= {sd_s[0], link.sdio};
    end
  end

  assign rise  = sclk_s[1] & ~sclk_s[2];
  assign fall  = ~sclk_s[1] & sclk_s[2];
  assign cs_n  = cs_s[1];
  assign sd_in = sd_s[1];

  // addresses written straight to the active copy
  function automatic logic is_direct(input logic [7:0] a);
    return (a == ADDR_CFG) || (a == ADDR_DIR_A) || (a == ADDR_DIR_B) ||
           (a == ADDR_DIR_C) || (a == ADDR_XFER);
  endfunction

  // serial frame sequencer
  always_comb begin
    logic [15:0] ins;
    logic [7:0]  nxa;
    logic [7:0]  wb;
    ins           = {instr_sr[14:0], sd_in};
    nxa           = lsb_first ? 8'(addr + 8'h01) : 8'(addr - 8'h01);
    wb            = lsb_first ? scp_rev8({rx_sr[6:0], sd_in}) : {rx_sr[6:0], sd_in};
    next_state    = state;
    next_bit_cnt  = bit_cnt;
    next_instr_sr = instr_sr;
    next_rx_sr    = rx_sr;
    next_tx_sr    = tx_sr;
    next_addr     = addr;
    next_left     = left;
    next_stream   = stream;
    next_is_rd    = is_rd;
    next_sd_o     = sd_o;
    next_sd_oe    = sd_oe;
    wr_en         = 1'b0;
    wr_addr       = addr;
    wr_data       = wb;
    xfer_en       = 1'b0;
    if (cs_n) begin
      // select high at any point drops the frame
      next_state   = ST_IDLE;
      next_bit_cnt = 4'h0;
      next_sd_oe   = 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          next_state   = ST_INSTR;
          next_bit_cnt = 4'h0;
        end
        ST_INSTR: begin
          if (rise) begin
            next_instr_sr = ins;
            next_bit_cnt  = 4'(bit_cnt + 4'h1);
            if (bit_cnt == INSTR_LAST) begin
              next_state   = ST_DATA;
              next_bit_cnt = 4'h0;
              next_is_rd   = ins[BIT_RD];
              next_addr    = ins[7:0];
              next_left    = {ins[BIT_LEN_HI], ins[BIT_LEN_LO]};
              next_stream  = ({ins[BIT_LEN_HI], ins[BIT_LEN_LO]} == LEN_STREAM);
              next_tx_sr   = lsb_first ? scp_rev8(shadow[ins[7:0]]) : shadow[ins[7:0]];
            end
          end
        end
        ST_DATA: begin
          if (rise) begin
            next_rx_sr   = {rx_sr[6:0], sd_in};
            next_bit_cnt = 4'(bit_cnt + 4'h1);
            if (bit_cnt[2:0] == BYTE_LAST) begin
              next_bit_cnt = 4'h0;
              wr_en        = ~is_rd;
              xfer_en      = ~is_rd && (addr == ADDR_XFER) && wb[BIT_XFER];
              next_addr    = nxa;
              next_tx_sr   = lsb_first ? scp_rev8(shadow[nxa]) : shadow[nxa];
              if (!stream) begin
                next_left = 2'(left - 2'h1);
                if (left == 2'h0) begin
                  next_state = ST_DONE;
                end
              end
            end
          end else if (fall && is_rd) begin
            // read data changes on the falling edge, held a full period
            next_sd_o  = tx_sr[7];
            next_sd_oe = 1'b1;
            next_tx_sr = {tx_sr[6:0], 1'b0};
          end
        end
        ST_DONE: begin
          // keep the last read bit on the wire until select rises
          next_state = ST_DONE;
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= ST_IDLE;
      bit_cnt  <= 4'h0;
      instr_sr <= 16'h0000;
      rx_sr    <= 8'h00;
      tx_sr    <= 8'h00;
      addr     <= 8'h00;
      left     <= 2'h0;
      stream   <= 1'b0;
      is_rd    <= 1'b0;
      sd_o     <= 1'b0;
      sd_oe    <= 1'b0;
    end else begin
      state    <= next_state;
      bit_cnt  <= next_bit_cnt;
      instr_sr <= next_instr_sr;
      rx_sr    <= next_rx_sr;
      tx_sr    <= next_tx_sr;
      addr     <= next_addr;
      left     <= next_left;
      stream   <= next_stream;
      is_rd    <= next_is_rd;
      sd_o     <= next_sd_o;
      sd_oe    <= next_sd_oe;
    end
  end

  // register space: shadow takes writes, active steers the chip
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 256; i++) begin
        shadow[i] <= 8'h00;
        active[i] <= 8'h00;
      end
      shadow[ADDR_CLOCK] <= CLOCK_RST;
      active[ADDR_CLOCK] <= CLOCK_RST;
    end else if (wr_en) begin
      // the transfer bit is never stored, so it reads back clear
      shadow[wr_addr] <= (wr_addr == ADDR_XFER) ? (wr_data & ~XFER_CMD) : wr_data;
      if (is_direct(wr_addr)) begin
        active[wr_addr] <= (wr_addr == ADDR_XFER) ? (wr_data & ~XFER_CMD) : wr_data;
      end else begin
        active[wr_addr] <= active[wr_addr];
      end
      if (xfer_en) begin
        // one update for every buffered byte at once
        for (int i = 0; i < 256; i++) begin
          if (!is_direct(8'(i))) begin
            active[i] <= shadow[i];
          end
        end
      end
    end
  end

  // user outputs straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_data   <= 8'h00;
      dcs_enable <= CLOCK_RST[BIT_DCS];
      lsb_first  <= 1'b0;
    end else begin
      cfg_data   <= active[cfg_addr];
      dcs_enable <= active[ADDR_CLOCK][BIT_DCS];
      lsb_first  <= active[ADDR_CFG][BIT_LSB];
    end
  end

  assign link.dev_o  = sd_o;
  assign link.dev_oe = sd_oe;

endmodule // scp_dev

// ==== core/scp_host.sv ====
// host end: apb slave registers driving one serial frame at a time
// assumes software keeps the lsb-first choice in step with the device
`timescale 1ns/1ps
module scp_host
  import scp_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // serial link
  scp_link_if.host         link
);

  typedef enum logic [1:0] {HS_IDLE, HS_RUN, HS_GAP} scp_host_state_t;

  logic [1:0]      sd_s;
  logic            acc;
  scp_host_state_t state;
  scp_host_state_t next_state;
  logic [11:0]     ctrl;
  logic [11:0]     next_ctrl;
  logic [31:0]     txd;
  logic [31:0]     next_txd;
  logic [31:0]     rxd;
  logic [31:0]     next_rxd;
  logic [7:0]      div;
  logic [7:0]      next_div;
  logic            done;
  logic            next_done;
  logic [7:0]      dcnt;
  logic [7:0]      next_dcnt;
  logic [5:0]      bidx;
  logic [5:0]      next_bidx;
  logic [47:0]     osr;
  logic [47:0]     next_osr;
  logic            sclk;
  logic            next_sclk;
  logic            cs_n;
  logic            next_cs_n;
  logic            m_oe;
  logic            next_m_oe;
  logic [31:0]     next_prdata;
  logic            next_pready;
  logic            next_pslverr;

  // returning data passes two flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sd_s <= 2'h3;
    end else begin
      sd_s <= {sd_s[0], link.sdio};
    end
  end

  assign acc = psel & penable & pready;

  // register access and frame engine
  always_comb begin
    logic [5:0]  last;
    logic        tick;
    logic [15:0] ins;
    logic        lsb;
    lsb          = ctrl[CTRL_LSB];
    last         = 6'(INSTR_W + 8 * ctrl[10:9] + 7);
    tick         = (dcnt == 8'(div - 8'h01));
    ins          = {ctrl[CTRL_RD], ctrl[10:9], 5'h00, ctrl[7:0]};
    next_state   = state;
    next_ctrl    = ctrl;
    next_txd     = txd;
    next_rxd     = rxd;
    next_div     = div;
    next_done    = done;
    next_dcnt    = (state == HS_IDLE || tick) ? 8'h00 : 8'(dcnt + 8'h01);
    next_bidx    = bidx;
    next_osr     = osr;
    next_sclk    = sclk;
    next_cs_n    = cs_n;
    next_m_oe    = m_oe;
    next_pready  = psel & ~penable & ~pready;
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (psel && !penable) begin
      case (paddr)
        H_CTRL:   next_prdata = {20'h00000, ctrl};
        H_TXDATA: next_prdata = txd;
        H_RXDATA: next_prdata = rxd;
        H_STATUS: next_prdata = {30'h0, done, state != HS_IDLE};
        H_DIV:    next_prdata = {24'h000000, div};
        default:  next_pslverr = 1'b1;
      endcase
    end
    case (state)
      HS_IDLE: begin
        if (acc && pwrite && paddr == H_CTRL) begin
          next_ctrl  = pwdata[11:0];
          next_state = HS_RUN;
          next_bidx  = 6'h00;
          next_cs_n  = 1'b0;
          next_m_oe  = 1'b1;
          next_osr   = {{pwdata[CTRL_RD], pwdata[10:9], 5'h00, pwdata[7:0]},
                        pwdata[CTRL_LSB] ? scp_rev8(txd[7:0]) : txd[7:0],
                        pwdata[CTRL_LSB] ? scp_rev8(txd[15:8]) : txd[15:8],
                        pwdata[CTRL_LSB] ? scp_rev8(txd[23:16]) : txd[23:16],
                        pwdata[CTRL_LSB] ? scp_rev8(txd[31:24]) : txd[31:24]};
        end
      end
      HS_RUN: begin
        if (tick && !sclk) begin
          next_sclk = 1'b1;
        end else if (tick) begin
          next_sclk = 1'b0;
          next_osr  = {osr[46:0], 1'b0};
          next_bidx = 6'(bidx + 6'h01);
          if (ins[BIT_RD] && bidx >= 6'(INSTR_W)) begin
            next_rxd = {rxd[30:0], sd_s[1]};
          end
          if (ins[BIT_RD] && bidx == 6'(INSTR_W - 1)) begin
            next_m_oe = 1'b0;
          end
          if (bidx == last) begin
            next_state = HS_GAP;
            next_cs_n  = 1'b1;
            next_m_oe  = 1'b0;
          end
        end
      end
      HS_GAP: begin
        if (tick) begin
          next_state = HS_IDLE;
          next_done  = 1'b1;
          if (lsb && ctrl[CTRL_RD]) begin
            next_rxd = {scp_rev8(rxd[31:24]), scp_rev8(rxd[23:16]), scp_rev8(rxd[15:8]), scp_rev8(rxd[7:0])};
          end
        end
      end
      default: begin
        next_state = HS_IDLE;
      end
    endcase
    if (acc && pwrite) begin
      if (paddr == H_TXDATA) begin
        next_txd = pwdata;
      end
      if (paddr == H_DIV && state == HS_IDLE) begin
        next_div = (pwdata[7:0] < DIV_MIN) ? DIV_MIN : pwdata[7:0];
      end
      // a finishing frame sets done over a clear in the same cycle
      if (paddr == H_STATUS && pwdata[1] && !(state == HS_GAP && tick)) begin
        next_done = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= HS_IDLE;
      ctrl    <= 12'h000;
      txd     <= 32'h0000_0000;
      rxd     <= 32'h0000_0000;
      div     <= DIV_RST;
      done    <= 1'b0;
      dcnt    <= 8'h00;
      bidx    <= 6'h00;
      osr     <= 48'h0;
      sclk    <= 1'b0;
      cs_n    <= 1'b1;
      m_oe    <= 1'b0;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      state   <= next_state;
      ctrl    <= next_ctrl;
      txd     <= next_txd;
      rxd     <= next_rxd;
      div     <= next_div;
      done    <= next_done;
      dcnt    <= next_dcnt;
      bidx    <= next_bidx;
      osr     <= next_osr;
      sclk    <= next_sclk;
      cs_n    <= next_cs_n;
      m_oe    <= next_m_oe;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  assign link.sclk          = sclk;
  assign link.port_select_n = cs_n;
  assign link.host_o        = osr[47];
  assign link.host_oe       = m_oe;

endmodule // scp_host

// ==== sim/scp_properties.sv ====
// link checker: watches the wires between the two ends
// assumes host divider at its reset value of 4
`timescale 1ns/1ps
module scp_properties (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link wires
  input wire logic sclk,
  input wire logic port_select_n,
  input wire logic host_o,
  input wire logic host_oe,
  input wire logic dev_o,
  input wire logic dev_oe,
  input wire logic sdio
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // two drivers on the data wire would fight
  AST_NO_CONTENTION: assert property (!(host_oe && dev_oe)) else $error("both ends drive data");
  // the host owns the data wire from the first instruction bit
  AST_HOST_DRIVES_AT_START: assert property ($fell(port_select_n) |-> host_oe && !dev_oe)
    else $error("host not driving at frame start");
  AST_DEV_QUIET_OUTSIDE: assert property ($rose(dev_oe) |-> !port_select_n && !host_oe)
    else $error("device drives outside a read");
  AST_DEV_RELEASE: assert property ($rose(port_select_n) |-> ##[0:5] !dev_oe)
    else $error("device holds data after deselect");
  AST_HOST_OE_IN_FRAME: assert property (host_oe |-> !port_select_n) else $error("host drives unselected");
  AST_CLOCK_STILL: assert property (port_select_n |-> !sclk) else $error("clock runs outside frame");
  AST_HIGH_HALF: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk) else $error("high half wrong");
  AST_LOW_HALF: assert property ($fell(sclk) |-> (!sclk) [*4]) else $error("low half too short");
  // data must not move while the clock is high, the sampling side may take it late
  AST_DEV_DATA_HELD: assert property (dev_oe && sclk && $past(sclk) |-> $stable(dev_o))
    else $error("read data moves while clock high");
  AST_HOST_DATA_HELD: assert property (host_oe && sclk && $past(sclk) |-> $stable(host_o))
    else $error("write data moves while clock high");

  // main scenarios
  COV_FRAME: cover property ($fell(port_select_n));
  COV_READ: cover property ($rose(dev_oe));
  COV_END: cover property ($rose(port_select_n));
endmodule // scp_properties

// ==== sim/serial_config_port_regs_tb_top.sv ====
// bench: host and device joined by one link, a second device bit-banged
// assumes host answers apb with no wait cycle and polls done in status
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module serial_config_port_regs_tb_top
  import scp_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, cfg_addr = 8'h09;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, last_err, dcs_enable, lsb_first;
  logic [7:0]  cfg_data, cfg_b;
  int          fail_count = 0, n_checks = 0;

  scp_link_if link();
  scp_link_if link_b();
  // second link idles deselected with the data wire released
  initial begin
    link_b.sclk <= 1'b0;
    link_b.port_select_n <= 1'b1;
    link_b.host_o <= 1'b1;
    link_b.host_oe <= 1'b0;
  end

  scp_host u_scp_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  scp_dev u_scp_dev (.pclk(pclk), .presetn(presetn), .link(link), .cfg_addr(cfg_addr),
    .cfg_data(cfg_data), .dcs_enable(dcs_enable), .lsb_first(lsb_first));
  scp_dev u_scp_dev_b (.pclk(pclk), .presetn(presetn), .link(link_b), .cfg_addr(8'h02),
    .cfg_data(cfg_b), .dcs_enable(), .lsb_first());
  scp_properties u_scp_properties (.pclk(pclk), .presetn(presetn), .sclk(link.sclk),
    .port_select_n(link.port_select_n), .host_o(link.host_o), .host_oe(link.host_oe),
    .dev_o(link.dev_o), .dev_oe(link.dev_oe), .sdio(link.sdio));

  always #20 pclk = ~pclk;

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin
      fail_count++;
      conclude();
    end
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one serial frame through the host; waits for done, then clears it
  task automatic xfer(input logic [7:0] a, input logic rd, input logic [1:0] len, input logic lsb,
                      input logic [31:0] tx);
    int i;
    apb(1'b1, H_TXDATA, tx);
    apb(1'b1, H_CTRL, {20'h0, lsb, len, rd, a});
    for (i = 0; i < 200; i++) begin
      apb(1'b0, H_STATUS, 32'h0);
      if (r[1] === 1'b1) break;
    end
    if (i == 200) begin
      fail_count++;
      conclude();
    end
    apb(1'b1, H_STATUS, 32'h2);
  endtask

  task automatic chk_cfg(input logic [7:0] a, input logic [7:0] e);
    cfg_addr <= a;
    repeat (2) @(posedge pclk);
    `CHK(cfg_data, e)
  endtask

  task automatic t_reset();
    chk_cfg(ADDR_CLOCK, CLOCK_RST);
    `CHK(dcs_enable, 1'b1)
    `CHK(lsb_first, 1'b0)
    apb(1'b0, H_DIV, 32'h0);
    `CHK(r[7:0], DIV_RST)
    apb(1'b0, 8'h14, 32'h0);
    `CHK({last_err, r}, 33'h100000000)
  endtask

  // buffered writes wait for the transfer bit, then land together
  task automatic t_buffered();
    xfer(8'h0e, 1'b0, 2'h0, 1'b0, 32'h0);
    xfer(ADDR_CLOCK, 1'b0, 2'h0, 1'b0, 32'h0);
    xfer(8'h0a, 1'b0, 2'h0, 1'b0, 32'h5a);
    chk_cfg(8'h0a, 8'h00);
    `CHK(dcs_enable, 1'b1)
    xfer(ADDR_CLOCK, 1'b1, 2'h0, 1'b0, 32'h0);
    apb(1'b0, H_RXDATA, 32'h0);
    `CHK(r[7:0], 8'h00)
    xfer(ADDR_XFER, 1'b0, 2'h0, 1'b0, {24'h0, XFER_CMD});
    `CHK(dcs_enable, 1'b0)
    chk_cfg(8'h0a, 8'h5a);
    xfer(ADDR_XFER, 1'b1, 2'h0, 1'b0, 32'h0);
    apb(1'b0, H_RXDATA, 32'h0);
    `CHK(r[7:0], 8'h00)
    xfer(ADDR_DIR_A, 1'b0, 2'h0, 1'b0, 32'h3c);
    chk_cfg(ADDR_DIR_A, 8'h3c);
  endtask

  // streaming write and read walk the address downwards
  task automatic t_stream();
    xfer(8'h0d, 1'b0, LEN_STREAM, 1'b0, 32'h11223344);
    xfer(8'h0d, 1'b1, LEN_STREAM, 1'b0, 32'h0);
    apb(1'b0, H_RXDATA, 32'h0);
    `CHK(r, 32'h44332211)
    xfer(8'h0b, 1'b1, 2'h1, 1'b0, 32'h0);
    apb(1'b0, H_RXDATA, 32'h0);
    `CHK(r[15:0], 16'h2211)
  endtask

  // lsb-first mode walks the address upwards
  task automatic t_lsb();
    xfer(ADDR_CFG, 1'b0, 2'h0, 1'b0, 32'h40);
    `CHK(lsb_first, 1'b1)
    xfer(8'h0c, 1'b0, 2'h1, 1'b1, 32'hb7c5);
    xfer(8'h0d, 1'b1, 2'h0, 1'b1, 32'h0);
    apb(1'b0, H_RXDATA, 32'h0);
    `CHK(r[7:0], 8'hb7)
    xfer(ADDR_CFG, 1'b0, 2'h0, 1'b1, 32'h0);
    `CHK(lsb_first, 1'b0)
  endtask

  // bench-made link clock, 4 pclk per half period gives 320 ns
  task automatic bit_b(input logic v);
    link_b.host_o <= v;
    link_b.host_oe <= 1'b1;
    repeat (4) @(posedge pclk);
    link_b.sclk <= 1'b1;
    repeat (4) @(posedge pclk);
    link_b.sclk <= 1'b0;
  endtask

  task automatic frame_b(input logic [23:0] w, input int n);
    link_b.port_select_n <= 1'b0;
    for (int k = 0; k < n; k++) begin
      bit_b(w[23 - k]);
    end
    repeat (4) @(posedge pclk);
    link_b.port_select_n <= 1'b1;
    link_b.host_oe <= 1'b0;
    repeat (12) @(posedge pclk);
  endtask

  // a frame cut mid-byte is dropped and the next one starts clean
  task automatic t_abort();
    frame_b(24'h0002ff, 20);
    `CHK(cfg_b, 8'h00)
    frame_b(24'h000281, 24);
    `CHK(cfg_b, 8'h81)
  endtask

  // a reset in mid-run brings every register back with no serial access
  task automatic t_rereset();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_cfg(ADDR_CLOCK, CLOCK_RST);
    `CHK(dcs_enable, 1'b1)
    `CHK(cfg_b, 8'h00)
    chk_cfg(ADDR_DIR_A, 8'h00);
    xfer(8'h0d, 1'b1, 2'h0, 1'b0, 32'h0);
    apb(1'b0, H_RXDATA, 32'h0);
    `CHK(r[7:0], 8'h00)
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_buffered();
    t_stream();
    t_lsb();
    t_abort();
    t_rereset();
    conclude();
  end
endmodule // serial_config_port_regs_tb_top
